// file: src/via_ctrl.sv
// Interrupt acknowledge logic: edge select, status word, ranking and acknowledge
// Summary of operation
// [R01] Pins 0-3: rise/fall select bits pick none, falling, rising or both edges.
// [R02] Pins 4-7 use same encoding in bits 7:4; lower bits read zero.
// [R03] Edge-select registers take bit and byte access; reset clears them.
// [R04] Status word byte/bit writable; enable and disable instructions set/clear gate.
// [R05] Vectored acknowledge or soft trap pushes status word and clears gate.
// [R06] Maskable acknowledge copies source level flag into in-service level.
// [R07] Returns and pop restore status word; push saves it.
// [R08] Reset loads status word with 02 hex.
// [R09] Non-maskable request ignores gate and priority, wins over all.
// [R10] Non-maskable acknowledge pushes status, PC; clears gate and level; loads vector.
// [R11] Non-maskable during its service held until return plus one instruction.
// [R12] Multiple non-maskable requests during service collapse into one.
// [R13] Maskable eligible when requested and unmasked; vectored needs gate set.
// [R14] While level bit is zero, low-priority requests are not acknowledged.
// [R15] Latency 7-32 clocks high priority, 8-33 low priority.
// [R16] Worst latency when request precedes a division instruction.
// [R17] High programmable group first; ties broken by fixed default priority.
// [R18] A pending request is taken as soon as it becomes acceptable.
// [R19] Maskable acknowledge pushes status, PC; clears gate; loads source vector.
// [R20] Service routines end with the interrupt return instruction.
// [R21] Level bit zero while high priority serviced, else one.
// [R22] Default priority 0 highest to 23 lowest, for simultaneous requests.
// [R23] Request flag set on request, cleared on acknowledge or reset.
// [R24] Same or higher priority request nests when gate enabled.
// [R25] Pins synchronised and compared with previous sample for edges.
module via_ctrl
  import via_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // External interrupt pins
  input  wire logic [NUM_PINS-1:0] ext_irq_pin_i,
  // Internal sources on lines 9..23 (0 = watchdog, 1..8 = pins)
  input  wire logic [NUM_SRC-1:0]  src_req_i,
  input  wire logic                nmi_req_i,
  // Mask and level flags from flag registers
  input  wire logic [NUM_SRC-1:0]  mask_flag_i,
  input  wire logic [NUM_SRC-1:0]  level_flag_i,
  // Special function register bus
  input  wire logic [15:0]         sfr_addr_i,
  input  wire logic                sfr_wr_i,
  input  wire logic [7:0]          sfr_wmask_i,
  input  wire logic [7:0]          sfr_wdata_i,
  output logic      [7:0]          sfr_rdata_o,
  output logic                     sfr_hit_o,
  // Core status word operations
  input  wire logic [2:0]          psw_op_i,
  input  wire logic [7:0]          psw_wmask_i,
  input  wire logic [7:0]          psw_wdata_i,
  input  wire logic                soft_trap_instr_i,
  input  wire logic                instr_done_i,
  input  wire logic                return_from_irq_i,
  // Acknowledge to core
  output logic                     ack_o,
  output logic                     ack_nmi_o,
  output logic [4:0]               ack_src_o,
  output logic [7:0]               push_psw_o,
  output logic [7:0]               program_status_o,
  output logic [NUM_SRC-1:0]       req_flag_o
);

  // Edge select registers, status word, pin samples, request flags and acknowledge state
  logic [7:0] rise_lo_q, rise_lo_d, fall_lo_q, fall_lo_d;
  logic [7:0] rise_hi_q, rise_hi_d, fall_hi_q, fall_hi_d;
  logic [7:0] psw_q, psw_d;
  logic [NUM_PINS-1:0] pin_s1_q, pin_s2_q, pin_prev_q;
  logic [NUM_SRC-1:0] req_q, req_d;
  logic nmi_pend_q, nmi_pend_d, nmi_busy_q, nmi_busy_d, hold_q, hold_d;
  logic ack_q, ack_d, ack_nmi_q, ack_nmi_d;
  logic [4:0] src_q, src_d;
  logic [7:0] push_q, push_d;

  // Bit-masked byte merge, shared by register and status writes
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wm,
                                       input logic [7:0] wd);
    merge = (old & ~wm) | (wd & wm);
  endfunction : merge

  // Register path: single bit writes use a one-hot write mask
  always_comb begin
    rise_lo_d = rise_lo_q;
    fall_lo_d = fall_lo_q;
    rise_hi_d = rise_hi_q;
    fall_hi_d = fall_hi_q;
    if (sfr_wr_i) begin
      case (sfr_addr_i) // [R03]
        ADDR_RISE_LO: rise_lo_d = merge(rise_lo_q, sfr_wmask_i, sfr_wdata_i) & LO_USED_MASK; // [R01]
        ADDR_FALL_LO: fall_lo_d = merge(fall_lo_q, sfr_wmask_i, sfr_wdata_i) & LO_USED_MASK; // [R01]
        ADDR_RISE_HI: rise_hi_d = merge(rise_hi_q, sfr_wmask_i, sfr_wdata_i) & HI_USED_MASK; // [R02]
        ADDR_FALL_HI: fall_hi_d = merge(fall_hi_q, sfr_wmask_i, sfr_wdata_i) & HI_USED_MASK; // [R02]
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero and no hit
  always_comb begin
    sfr_hit_o   = 1'b1;
    case (sfr_addr_i)
      ADDR_RISE_LO: sfr_rdata_o = rise_lo_q;
      ADDR_FALL_LO: sfr_rdata_o = fall_lo_q;
      ADDR_RISE_HI: sfr_rdata_o = rise_hi_q;
      ADDR_FALL_HI: sfr_rdata_o = fall_hi_q;
      default: begin
        sfr_rdata_o = 8'h00;
        sfr_hit_o   = 1'b0;
      end
    endcase
  end

  // Edge detection from synchronised pins
  logic [NUM_PINS-1:0] rise_sel, fall_sel, pin_edge;
  assign rise_sel = {rise_hi_q[7:4], rise_lo_q[3:0]};
  assign fall_sel = {fall_hi_q[7:4], fall_lo_q[3:0]};
  assign pin_edge = (rise_sel & pin_s2_q & ~pin_prev_q)
                  | (fall_sel & ~pin_s2_q & pin_prev_q); // [R25] [R01] [R02]

  // Ranking: lowest index wins within the high group, else low group
  logic [NUM_SRC-1:0] elig;
  logic               found;
  logic [4:0]         win;
  logic               win_low;
  always_comb begin
    elig    = req_q & ~mask_flag_i; // [R13]
    found   = 1'b0;
    win     = 5'h00;
    win_low = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin // [R22]
      if (elig[i] && !level_flag_i[i]) begin // [R17]
        found = 1'b1;
        win   = 5'(i);
      end
    end
    if (!found && psw_q[PSW_LEVEL_BIT]) begin // [R14] [R24]
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (elig[i]) begin
          found   = 1'b1;
          win     = 5'(i);
          win_low = 1'b1;
        end
      end
    end
  end

  // Acknowledge decision at instruction boundaries
  logic take_nmi, take_mi;
  assign take_nmi = instr_done_i && !hold_q && nmi_pend_q && !nmi_busy_q; // [R09] [R11]
  assign take_mi  = instr_done_i && !hold_q && !take_nmi && !nmi_busy_q
                  && psw_q[PSW_GATE_BIT] && found; // [R13] [R18] [R15] [R16]

  // Next state of flags, status word and acknowledge outputs
  always_comb begin
    req_d      = req_q;
    psw_d      = psw_q;
    nmi_pend_d = nmi_pend_q;
    nmi_busy_d = nmi_busy_q;
    hold_d     = hold_q;
    ack_d      = 1'b0;
    ack_nmi_d  = 1'b0;
    src_d      = src_q;
    push_d     = push_q;
    // Status word operations from the core
    case (psw_op_i)
      VIA_OP_GATE_ON:  psw_d[PSW_GATE_BIT] = 1'b1; // [R04]
      VIA_OP_GATE_OFF: psw_d[PSW_GATE_BIT] = 1'b0; // [R04]
      VIA_OP_RESTORE: psw_d = psw_wdata_i; // [R07]
      VIA_OP_WRITE:   psw_d = merge(psw_q, psw_wmask_i, psw_wdata_i); // [R04]
      default: ;
    endcase
    // One main-routine instruction must complete after a return
    if (return_from_irq_i) begin
      hold_d = 1'b1; // [R11]
      if (nmi_busy_q) begin
        nmi_busy_d = 1'b0;
      end
    end else if (instr_done_i) begin
      hold_d = 1'b0;
    end
    if (soft_trap_instr_i) begin
      push_d = psw_q;
      psw_d[PSW_GATE_BIT] = 1'b0; // [R05]
    end
    if (take_nmi) begin
      push_d     = psw_q; // [R10]
      psw_d[PSW_GATE_BIT]  = 1'b0;
      psw_d[PSW_LEVEL_BIT] = 1'b0; // [R10]
      nmi_busy_d = 1'b1;
      ack_d      = 1'b1;
      ack_nmi_d  = 1'b1;
      nmi_pend_d = 1'b0;
    end else if (take_mi) begin
      push_d     = psw_q; // [R05] [R19]
      psw_d[PSW_GATE_BIT]  = 1'b0; // [R19]
      psw_d[PSW_LEVEL_BIT] = win_low; // [R06] [R21]
      ack_d      = 1'b1;
      src_d      = win;
      req_d[win] = 1'b0; // [R23]
    end
    // New requests win over the acknowledge clear
    req_d = req_d | src_req_i | {{(NUM_SRC-NUM_PINS-1){1'b0}}, pin_edge, 1'b0}; // [R23]
    if (nmi_req_i) begin
      nmi_pend_d = 1'b1; // [R12]
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_lo_q  <= EDGE_RST; // [R03]
      fall_lo_q  <= EDGE_RST;
      rise_hi_q  <= EDGE_RST;
      fall_hi_q  <= EDGE_RST;
      psw_q      <= PSW_RST; // [R08]
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_prev_q <= '0;
      req_q      <= '0;
      nmi_pend_q <= 1'b0;
      nmi_busy_q <= 1'b0;
      hold_q     <= 1'b0;
      ack_q      <= 1'b0;
      ack_nmi_q  <= 1'b0;
      src_q      <= 5'h00;
      push_q     <= 8'h00;
    end else begin
      rise_lo_q  <= rise_lo_d;
      fall_lo_q  <= fall_lo_d;
      rise_hi_q  <= rise_hi_d;
      fall_hi_q  <= fall_hi_d;
      psw_q      <= psw_d;
      pin_s1_q   <= ext_irq_pin_i;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
      req_q      <= req_d;
      nmi_pend_q <= nmi_pend_d;
      nmi_busy_q <= nmi_busy_d;
      hold_q     <= hold_d;
      ack_q      <= ack_d;
      ack_nmi_q  <= ack_nmi_d;
      src_q      <= src_d;
      push_q     <= push_d;
    end
  end

  assign ack_o            = ack_q;
  assign ack_nmi_o        = ack_nmi_q;
  assign ack_src_o        = src_q;
  assign push_psw_o       = push_q;
  assign program_status_o = psw_q;
  assign req_flag_o       = req_q;

  // Checks; reset ones use the release edge so the first clock of the run is not judged
  a_reset_psw: assert property (@(posedge clk_i) $fell(rst_i) |-> psw_q == PSW_RST) // [R08]
    else $error("status word not 02 after reset");
  a_reset_edges: assert property (@(posedge clk_i) $fell(rst_i) |-> // [R03] [R23]
    req_q == '0 && rise_lo_q == EDGE_RST && fall_lo_q == EDGE_RST && rise_hi_q == EDGE_RST && fall_hi_q == EDGE_RST)
    else $error("edge selects or request flags not cleared by reset");
  a_gate_ops: assert property (@(posedge clk_i) disable iff (rst_i) // [R04]
    psw_op_i == VIA_OP_GATE_ON && !take_nmi && !take_mi && !soft_trap_instr_i |=> psw_q[PSW_GATE_BIT])
    else $error("enable instruction did not open gate");
  a_nmi_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    take_nmi && psw_op_i == 3'h0 |=> !psw_q[PSW_GATE_BIT] && !psw_q[PSW_LEVEL_BIT] && ack_nmi_q)
    else $error("nmi acknowledge did not clear flags");
  a_nmi_gateless: assert property (@(posedge clk_i) disable iff (rst_i) // [R09]
    instr_done_i && !hold_q && nmi_pend_q && !nmi_busy_q && !psw_q[PSW_GATE_BIT] |=> ack_nmi_q && ack_q)
    else $error("nmi not taken with gate closed");
  a_mi_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    take_mi |-> psw_q[PSW_GATE_BIT] && !mask_flag_i[win] && req_q[win])
    else $error("maskable taken while gated");
  a_mi_ack: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    take_mi |=> ack_q && !ack_nmi_q && src_q == $past(win) && push_q == $past(psw_q) && !psw_q[PSW_GATE_BIT])
    else $error("maskable acknowledge incomplete");
  a_mi_level: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
    take_mi && psw_op_i == 3'h0 |=> psw_q[PSW_LEVEL_BIT] == $past(level_flag_i[win]))
    else $error("level bit not copied");
  a_low_blocked: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    take_mi && !psw_q[PSW_LEVEL_BIT] |-> !level_flag_i[win])
    else $error("low priority taken during high service");
  a_trap_push: assert property (@(posedge clk_i) disable iff (rst_i) // [R05]
    soft_trap_instr_i && !take_nmi && !take_mi |=> push_q == $past(psw_q) && !psw_q[PSW_GATE_BIT])
    else $error("soft trap did not save status word");
  a_nmi_nest: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    nmi_busy_q |-> !take_nmi && !take_mi)
    else $error("acknowledge during nmi service");
  a_hold_block: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    hold_q |-> !take_nmi && !take_mi)
    else $error("acknowledge inside return window");
  a_nmi_pend: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    nmi_req_i |=> nmi_pend_q)
    else $error("nmi request not held pending");
  a_lo_bits: assert property (@(posedge clk_i) disable iff (rst_i) // [R02]
    rise_lo_q[7:4] == 4'h0 && fall_lo_q[7:4] == 4'h0 && rise_hi_q[3:0] == 4'h0 && fall_hi_q[3:0] == 4'h0)
    else $error("unused edge bits nonzero");
  a_edge_sets: assert property (@(posedge clk_i) disable iff (rst_i) // [R25]
    |pin_edge |=> (req_q[NUM_PINS:1] & $past(pin_edge)) == $past(pin_edge))
    else $error("pin edge did not set request flag");
  a_ack_clears: assert property (@(posedge clk_i) disable iff (rst_i) // [R23]
    take_mi && !src_req_i[win] && !(win >= 5'd1 && win <= 5'd8) |=> !req_q[$past(win)])
    else $error("request flag not cleared");
  a_nmi_first: assert property (@(posedge clk_i) disable iff (rst_i) // [R09]
    take_nmi |-> !take_mi)
    else $error("nmi lost to maskable");

endmodule : via_ctrl

// file: include/via_pkg.sv
// Package of constants and types for the vectored interrupt acknowledge block
package via_pkg;
  // Register byte addresses on the special-function register bus
  localparam logic [15:0] ADDR_RISE_LO   = 16'hff48;
  localparam logic [15:0] ADDR_FALL_LO   = 16'hff49;
  localparam logic [15:0] ADDR_RISE_HI   = 16'hff7c;
  localparam logic [15:0] ADDR_FALL_HI   = 16'hff7d;
  // Reset values and used-bit masks
  localparam logic [7:0]  EDGE_RST       = 8'h00;
  localparam logic [7:0]  PSW_RST        = 8'h02;
  localparam logic [7:0]  LO_USED_MASK   = 8'h0f;
  localparam logic [7:0]  HI_USED_MASK   = 8'hf0;
  // Status word field positions
  localparam int          PSW_GATE_BIT   = 7;
  localparam int          PSW_LEVEL_BIT  = 1;
  // Latency figures in CPU clocks; source and pin counts
  localparam int          LAT_HIGH_MIN   = 7;
  localparam int          LAT_HIGH_MAX   = 32;
  localparam int          LAT_LOW_MIN    = 8;
  localparam int          LAT_LOW_MAX    = 33;
  localparam int          NUM_SRC        = 24;
  localparam int          NUM_PINS       = 8;
  // Core event codes for status word handling
  typedef enum logic [2:0] {
    VIA_OP_NONE   = 3'h0,
    VIA_OP_GATE_ON  = 3'h1,
    VIA_OP_GATE_OFF = 3'h2,
    VIA_OP_RESTORE = 3'h3,
    VIA_OP_WRITE  = 3'h4
  } via_op_e;
endpackage : via_pkg

// file: bench/via_core_model.sv
// Behavioural CPU core model: instruction boundaries, returns and acknowledge capture
module via_core_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Requests from the bench
  input  wire logic       start_i,
  input  wire logic       ret_i,
  input  wire logic [3:0] gap_i,
  // Acknowledge from the block
  input  wire logic       ack_i,
  input  wire logic       ack_nmi_i,
  // Core events and captured results
  output logic            instr_done_o,
  output logic            return_o,
  output logic            busy_o,
  output logic            acked_o,
  output logic            nmi_acked_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {instr_done_o, return_o, busy_o, acked_o, nmi_acked_o} = 5'h00;
  end
  // Instruction runs gap cycles, optional return, then one boundary pulse
  // Pulses are driven on the falling edge so the block samples settled levels
  always begin
    @(posedge clk_i);
    if (start_i && !rst_i) begin
      busy_o = 1'b1;
      repeat (gap_i) @(negedge clk_i);
      @(negedge clk_i);
      if (ret_i) begin
        return_o = 1'b1;
        @(negedge clk_i);
        return_o = 1'b0;
      end
      instr_done_o = 1'b1;
      @(negedge clk_i);
      instr_done_o = 1'b0;
      acked_o      = ack_i; // Acknowledge stands one cycle after the boundary
      nmi_acked_o  = ack_nmi_i;
      busy_o       = 1'b0;
    end
  end
endmodule : via_core_model

// file: bench/via_ctrl_tb_top.sv
// Self-checking bench for the interrupt acknowledge block
module via_ctrl_tb_top
  import via_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Design inputs
  logic        clk_i = 1'b0, rst_i = 1'b1, nmi_req_i = 1'b0, sfr_wr_i = 1'b0, soft_trap_instr_i = 1'b0;
  logic [7:0]  ext_irq_pin_i = 8'h00, sfr_wmask_i = 8'h00, sfr_wdata_i = 8'h00, psw_wmask_i = 8'h00;
  logic [7:0]  psw_wdata_i = 8'h00;
  logic [23:0] src_req_i = 24'h000000, mask_flag_i = 24'hffffff, level_flag_i = 24'hffffff;
  logic [15:0] sfr_addr_i = 16'h0000;
  logic [2:0]  psw_op_i = 3'h0;
  // Design outputs and core model links
  logic [7:0]  sfr_rdata_o, push_psw_o, program_status_o;
  logic [23:0] req_flag_o;
  logic [4:0]  ack_src_o;
  logic        sfr_hit_o, ack_o, ack_nmi_o, instr_done, ret_pulse, busy, acked, nmi_acked;
  logic        start = 1'b0, ret = 1'b0;
  logic [3:0]  gap = 4'h0;
  // Reference state of the model
  logic [23:0] flags = 24'h000000;
  logic [7:0]  program_status = PSW_RST, regs [4];
  logic [31:0] seed = 32'hc973;
  int          errors = 0, total_checks = 0;
  localparam logic [15:0] ADDRS [4] = '{ADDR_RISE_LO, ADDR_FALL_LO, ADDR_RISE_HI, ADDR_FALL_HI};
  localparam logic [7:0]  USED [4]  = '{LO_USED_MASK, LO_USED_MASK, HI_USED_MASK, HI_USED_MASK};

  always #5 clk_i = ~clk_i;

  via_ctrl u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ext_irq_pin_i(ext_irq_pin_i), .src_req_i(src_req_i), .nmi_req_i(nmi_req_i),
    .mask_flag_i(mask_flag_i), .level_flag_i(level_flag_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wmask_i(sfr_wmask_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
    .psw_op_i(psw_op_i), .psw_wmask_i(psw_wmask_i), .psw_wdata_i(psw_wdata_i),
    .soft_trap_instr_i(soft_trap_instr_i), .instr_done_i(instr_done), .return_from_irq_i(ret_pulse),
    .ack_o(ack_o), .ack_nmi_o(ack_nmi_o), .ack_src_o(ack_src_o), .push_psw_o(push_psw_o),
    .program_status_o(program_status_o), .req_flag_o(req_flag_o));
  via_core_model u_core (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .ret_i(ret), .gap_i(gap), .ack_i(ack_o),
    .ack_nmi_i(ack_nmi_o), .instr_done_o(instr_done), .return_o(ret_pulse), .busy_o(busy), .acked_o(acked),
    .nmi_acked_o(nmi_acked));

  // Fixed-seed shift register keeps the run repeatable
  function automatic logic [31:0] next_rand();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : next_rand
  // Winner: high group first, then lowest index; -1 when nothing may be taken
  function automatic int pick();
    for (int g = 0; g < 2; g++)
      for (int i = 0; i < 24; i++)
        if (flags[i] && !mask_flag_i[i] && level_flag_i[i] == g && program_status[7] && (g == 0 || program_status[1])) return i;
    return -1;
  endfunction : pick
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register write, then read back the kept bits
  task automatic wr(input int i, input logic [7:0] m, input logic [7:0] d);
    @(negedge clk_i) {sfr_addr_i, sfr_wmask_i, sfr_wdata_i, sfr_wr_i} = {ADDRS[i], m, d, 1'b1};
    @(negedge clk_i) sfr_wr_i = 1'b0;
    regs[i] = ((regs[i] & ~m) | (d & m)) & USED[i];
    #1 chk(sfr_rdata_o, regs[i]);
  endtask : wr
  // One core instruction through the partner, with a bounded wait
  task automatic run(input logic r);
    @(negedge clk_i) {start, ret, gap} = {1'b1, r, 4'(next_rand())};
    @(negedge clk_i) start = 1'b0;
    for (int k = 0; k < 50 && busy; k++) @(posedge clk_i);
    #1;
    if (busy !== 1'b0) begin
      errors++;
      print_verdict();
    end
  endtask : run
  // Status word operation, mirrored in the reference
  task automatic pop(input logic [2:0] o, input logic [7:0] m, input logic [7:0] d);
    @(negedge clk_i) {psw_op_i, psw_wmask_i, psw_wdata_i} = {o, m, d};
    @(negedge clk_i) psw_op_i = VIA_OP_NONE;
    case (o)
      VIA_OP_GATE_ON:  program_status[7] = 1'b1;
      VIA_OP_GATE_OFF: program_status[7] = 1'b0;
      VIA_OP_RESTORE:  program_status = d;
      default:         program_status = (program_status & ~m) | (d & m);
    endcase
    #1 chk(program_status_o, program_status);
  endtask : pop
  task automatic step(input logic [2:0] o, input logic [7:0] d);
    int         e;
    logic [7:0] p;
    pop(o, 8'hff, d);
    e = pick();
    p = program_status;
    run(1'b0);
    chk(acked, e >= 0);
    if (e >= 0) begin
      chk(ack_src_o, e);
      chk(push_psw_o, p);
      {flags[e], program_status[7], program_status[1]} = {1'b0, 1'b0, level_flag_i[e]};
    end
    chk(program_status_o, program_status);
    chk(req_flag_o, flags);
  endtask : step

  // Main sequence
  initial begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i) sfr_addr_i = ADDRS[i];
      #1 chk(sfr_rdata_o, EDGE_RST);
      chk(sfr_hit_o, 1'b1);
      regs[i] = EDGE_RST;
      wr(i, 8'hff, 8'(next_rand()));
      wr(i, 8'h01 << (next_rand() % 8), 8'(next_rand()));
    end
    @(negedge clk_i) sfr_addr_i = 16'hff4a;
    #1 chk(sfr_hit_o, 1'b0);
    chk(program_status_o, PSW_RST);
    // Per pin: none, falling, rising, both
    wr(0, 8'hff, 8'h0c);
    wr(1, 8'hff, 8'h0a);
    wr(2, 8'hff, 8'hc0);
    wr(3, 8'hff, 8'ha0);
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_i) ext_irq_pin_i = ~ext_irq_pin_i;
      repeat (5) @(negedge clk_i);
      for (int n = 0; n < 8; n++) if (regs[(n / 4) * 2 + k][n]) flags[n + 1] = 1'b1;
      chk(req_flag_o, flags);
    end
    run(1'b0);
    chk(acked, 1'b0);
    // Random sources, masks and levels; drained by the reference winner
    for (int r = 0; r < 2; r++) begin
      @(negedge clk_i) {mask_flag_i, level_flag_i} = {24'(r ? 0 : next_rand()), 24'(next_rand())};
      src_req_i = 24'(next_rand());
      flags = flags | src_req_i;
      @(negedge clk_i) src_req_i = 24'h000000;
      repeat (40) begin
        step(VIA_OP_GATE_ON, 8'h00);
        if (acked !== 1'b1) step(VIA_OP_RESTORE, 8'h82);
      end
    end
    pop(VIA_OP_RESTORE, 8'hff, 8'h83);
    @(negedge clk_i) soft_trap_instr_i = 1'b1;
    @(negedge clk_i) soft_trap_instr_i = 1'b0;
    #1 chk(push_psw_o, 8'h83);
    program_status[7] = 1'b0;
    chk(program_status_o, program_status);
    pop(VIA_OP_WRITE, 8'h80, 8'hff);
    pop(VIA_OP_GATE_OFF, 8'h00, 8'h00);
    // Non-maskable: taken with gate closed, held in service, collapsed
    @(negedge clk_i) nmi_req_i = 1'b1;
    @(negedge clk_i) nmi_req_i = 1'b0;
    run(1'b0);
    chk(nmi_acked, 1'b1);
    chk(push_psw_o, program_status);
    {program_status[7], program_status[1]} = 2'b00;
    chk(program_status_o, program_status);
    repeat (2) begin
      @(negedge clk_i) nmi_req_i = 1'b1;
      @(negedge clk_i) nmi_req_i = 1'b0;
    end
    run(1'b0);
    chk(nmi_acked, 1'b0);
    // Return boundary itself must not take the held request
    run(1'b1);
    chk(nmi_acked, 1'b0);
    // Exactly one acknowledge, at the first main-routine boundary
    for (int k = 0; k < 3; k++) begin
      run(1'b0);
      chk(nmi_acked, k == 0);
    end
    // Mid-run reset clears flags, edge selects and status word
    @(negedge clk_i) src_req_i = 24'hffffff;
    @(negedge clk_i) src_req_i = 24'h000000;
    rst_i = 1'b1;
    #1 chk(req_flag_o, 24'hffffff);
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    #1 chk(req_flag_o, 24'h000000);
    chk(program_status_o, PSW_RST);
    chk(sfr_rdata_o, EDGE_RST);
    print_verdict();
  end
endmodule : via_ctrl_tb_top
